// ### logic/gpio_function_mux.sv
// Configuration registers and function multiplexing of the three general pins
// Notes on behaviour
// [RL1] Pad-mode bits 7:5 select pad electrical mode
// [RL2] Pad mode resets to 011, open-drain low
// [RL3] Software avoids reserved pad-mode codes 101-111
// [RL4] Function resets to 00, repeater active
// [RL5] 02 static output at polarity; 01 input
// [RL6] 03: pin high disables CAN transmitter
// [RL7] 04: interrupt output, active low by default
// [RL8] Pin one 06: receive data on both
// [RL9] Pin one 08: receive data only here
// [RL10] Pin two 05: both transmit inputs drive
// [RL11] Pin two 07: only this pin transmits
// [RL12] 09-12 and 16 show internal status
// [RL13] Status outputs active high unless inverted
// [RL14] 0B second-transmit stuck, pins one/three
// [RL15] 0E shows bus biasing, high when active
// [RL16] 13/14/15 edges qualify wake when enabled
// [RL17] Polarity register bits 2:0, reset zero
// [RL18] Software avoids reserved function codes
`timescale 1ns/10ps
`include "gpio_function_mux_regs.svh"

module gpio_function_mux #(
	parameter int NUM_PINS = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr_en,
	input wire logic [`ADDR_WIDTH-1:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data_q,
	input wire logic general_pin_one_in,
	output logic general_pin_one_out,
	output logic general_pin_one_oe,
	input wire logic general_pin_two_in,
	output logic general_pin_two_out,
	output logic general_pin_two_oe,
	input wire logic general_pin_three_in,
	output logic general_pin_three_out,
	output logic general_pin_three_oe,
	output logic [2:0] pad_pull_up_q,
	output logic [2:0] pad_pull_down_q,
	input wire logic repeat_src,
	input wire logic rxd_bus,
	input wire logic txd_primary,
	input wire logic transmit_disable_input,
	input wire gpio_function_mux_pkg::core_status_t core_status,
	output logic rxd_out_q,
	output logic can_tx_q,
	output logic tx_disable_q,
	output logic [2:0] wake_event_q
);

	// The register map has exactly three pin registers, so other counts are refused
	if (NUM_PINS != 3)
	begin : g_bad_pin_count
		$error("gpio_function_mux serves exactly three pins");
	end

	gpio_function_mux_pkg::pin_cfg_t cfg_q [3];
	gpio_function_mux_pkg::pin_drive_t drv [3];
	gpio_function_mux_pkg::pad_ctrl_t ctrl [3];
	logic [2:0] polarity_q;
	logic [2:0] wake_enable_q;
	logic [2:0] wake_status_q;
	logic [2:0] prev_in_q;
	logic edge_armed_q;
	logic [2:0] pin_in;
	logic [2:0] wake_qual;
	logic [2:0] tx_disable_req;
	logic tx2_both;
	logic tx2_only;
	logic w1c_hit;
	logic [2:0] clear_mask;
	logic [7:0] rd_d;

	// Write strobe decode, shared by every writable register
	function automatic logic wr_hit(
		input logic en,
		input logic [`ADDR_WIDTH-1:0] addr,
		input logic [`ADDR_WIDTH-1:0] target
	);
		wr_hit = en && addr == target;
	endfunction

	assign pin_in = {general_pin_three_in, general_pin_two_in, general_pin_one_in};
	assign tx2_both = cfg_q[1].func == `FN_TX2_BOTH;
	assign tx2_only = cfg_q[1].func == `FN_TX2_ONLY;
	assign w1c_hit = wr_hit(reg_wr_en, reg_addr, `ADDR_WAKE_STATUS);
	// Only bits written as one clear; the rest of the status is kept
	assign clear_mask = w1c_hit ? reg_wr_data[2:0] : 3'h0;

	function automatic logic is_status_fn(input logic [4:0] func);
		is_status_fn = (func >= `FN_UNDERVOLT && func <= `FN_LISTEN_ONLY) || func == `FN_INHIBIT;
	endfunction

	// Raw status level for status-type functions, before polarity
	function automatic logic status_level(
		input logic [4:0] func,
		input gpio_function_mux_pkg::core_status_t st,
		input logic tx2_active
	);
		status_level = 1'b0;
		case (func) // RL12
			`FN_UNDERVOLT: status_level = st.undervoltage;
			`FN_TX_STUCK: status_level = st.tx_stuck;
			`FN_TX2_STUCK: status_level = st.tx2_stuck & tx2_active; // RL14
			`FN_WAKE_PATTERN: status_level = st.wake_pattern;
			`FN_WAKE_FRAME: status_level = st.wake_frame;
			`FN_BUS_BIAS: status_level = st.bus_bias; // RL15
			`FN_WAKE_RISE: status_level = st.wake_rise;
			`FN_WAKE_FALL: status_level = st.wake_fall;
			`FN_TX_READY: status_level = st.tx_ready;
			`FN_LISTEN_ONLY: status_level = st.listen_only;
			`FN_INHIBIT: status_level = st.inhibit_two;
			default: status_level = 1'b0;
		endcase
	endfunction

	// What the selected function asks of one pin; idx gates pin-specific codes
	function automatic gpio_function_mux_pkg::pin_drive_t pin_drive(
		input logic [4:0] func,
		input logic pol,
		input int idx,
		input gpio_function_mux_pkg::core_status_t st,
		input logic tx2_active,
		input logic rxd,
		input logic rep
	);
		pin_drive = '0;
		if (func == `FN_REPEATER)
			pin_drive = '{drive: 1'b1, level: rep}; // RL4
		else if (func == `FN_DIG_OUT)
			pin_drive = '{drive: 1'b1, level: pol}; // RL5
		else if (func == `FN_IRQ)
			pin_drive = '{drive: 1'b1, level: st.irq_req ? pol : ~pol}; // RL7
		else if ((func == `FN_RX2_BOTH || func == `FN_RX2_ONLY) && idx == 0)
			pin_drive = '{drive: 1'b1, level: rxd}; // RL8 RL9
		else if (func == `FN_TX2_STUCK && idx == 1)
			pin_drive = '0; // RL14
		else if (is_status_fn(func))
			pin_drive = '{drive: 1'b1, level: status_level(func, st, tx2_active) ^ pol}; // RL13
		else
			// Inputs and reserved codes leave the pin undriven
			pin_drive = '0; // RL18
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pin
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					cfg_q[gi].pad_mode <= `PAD_MODE_RESET; // RL2
					cfg_q[gi].func <= `FUNC_RESET; // RL4
				end
				else if (wr_hit(reg_wr_en, reg_addr, `ADDR_PIN_ONE_CONFIG + `ADDR_WIDTH'(gi)))
				begin
					cfg_q[gi].pad_mode <= reg_wr_data[`PAD_MODE_MSB:`PAD_MODE_LSB]; // RL1
					cfg_q[gi].func <= reg_wr_data[`FUNC_MSB:`FUNC_LSB];
				end
			end

			always_comb
			begin
				drv[gi] = pin_drive(cfg_q[gi].func, polarity_q[gi], gi, core_status,
					tx2_both | tx2_only, rxd_bus, repeat_src);
			end

			pad_driver u_pad (
				.clk_sys(clk_sys),
				.rst(rst),
				.pad_mode(cfg_q[gi].pad_mode),
				.drv(drv[gi]),
				.ctrl_q(ctrl[gi])
			);

			assign pad_pull_up_q[gi] = ctrl[gi].pull_up;
			assign pad_pull_down_q[gi] = ctrl[gi].pull_down;

			assign tx_disable_req[gi] = cfg_q[gi].func == `FN_TX_DISABLE && pin_in[gi]; // RL6

			// Edge qualification compares against the previous sampled level
			assign wake_qual[gi] = edge_armed_q && wake_enable_q[gi] &&
				((pin_in[gi] && !prev_in_q[gi] &&
				(cfg_q[gi].func == `FN_EDGE_RISE || cfg_q[gi].func == `FN_EDGE_BOTH)) ||
				(!pin_in[gi] && prev_in_q[gi] &&
				(cfg_q[gi].func == `FN_EDGE_FALL || cfg_q[gi].func == `FN_EDGE_BOTH))); // RL16
		end
	endgenerate

	assign general_pin_one_out = ctrl[0].out;
	assign general_pin_one_oe = ctrl[0].oe;
	assign general_pin_two_out = ctrl[1].out;
	assign general_pin_two_oe = ctrl[1].oe;
	assign general_pin_three_out = ctrl[2].out;
	assign general_pin_three_oe = ctrl[2].oe;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			polarity_q <= `POLARITY_RESET; // RL17
		else if (wr_hit(reg_wr_en, reg_addr, `ADDR_POLARITY))
			polarity_q <= reg_wr_data[2:0]; // RL17
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			wake_enable_q <= `WAKE_ENABLE_RESET;
		else if (wr_hit(reg_wr_en, reg_addr, `ADDR_WAKE_ENABLE))
			wake_enable_q <= reg_wr_data[2:0];
	end

	// The first cycle after reset has no valid previous level, so edges wait one cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			prev_in_q <= 3'h0;
			edge_armed_q <= 1'b0;
		end
		else
		begin
			prev_in_q <= pin_in;
			edge_armed_q <= 1'b1;
		end
	end

	// A new edge in the clearing cycle keeps its bit set
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wake_status_q <= 3'h0;
			wake_event_q <= 3'h0;
		end
		else
		begin
			wake_status_q <= wake_qual | (wake_status_q & ~clear_mask); // RL16
			wake_event_q <= wake_qual;
		end
	end

	// Transmit path: a low on either active input is dominant
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			can_tx_q <= 1'b1;
			tx_disable_q <= 1'b0;
		end
		else
		begin
			if (tx2_only)
				can_tx_q <= general_pin_two_in; // RL11
			else if (tx2_both)
				can_tx_q <= txd_primary & general_pin_two_in; // RL10
			else
				can_tx_q <= txd_primary;
			tx_disable_q <= transmit_disable_input | (|tx_disable_req); // RL6
		end
	end

	// Receive path held recessive while pin one takes the data alone
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rxd_out_q <= 1'b1;
		else if (cfg_q[0].func == `FN_RX2_ONLY)
			rxd_out_q <= 1'b1; // RL9
		else
			rxd_out_q <= rxd_bus; // RL8
	end

	// Read data answers one edge late, from the address held at that edge
	always_comb
	begin
		rd_d = 8'h00;
		case (reg_addr)
			`ADDR_PIN_ONE_CONFIG: rd_d = cfg_q[0];
			`ADDR_PIN_TWO_CONFIG: rd_d = cfg_q[1];
			`ADDR_PIN_THREE_CONFIG: rd_d = cfg_q[2];
			`ADDR_POLARITY: rd_d = {5'h00, polarity_q};
			`ADDR_WAKE_ENABLE: rd_d = {5'h00, wake_enable_q};
			`ADDR_WAKE_STATUS: rd_d = {5'h00, wake_status_q};
			`ADDR_PIN_STATUS: rd_d = {4'h0, transmit_disable_input, pin_in};
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			reg_rd_data_q <= 8'h00;
		else
			reg_rd_data_q <= rd_d;
	end

endmodule

// ### logic/pad_driver.sv
// Electrical pad control of one general pin, driven from its pad-mode field
`timescale 1ns/10ps
`include "gpio_function_mux_regs.svh"

module pad_driver (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] pad_mode,
	input wire gpio_function_mux_pkg::pin_drive_t drv,
	output gpio_function_mux_pkg::pad_ctrl_t ctrl_q
);

	gpio_function_mux_pkg::pad_ctrl_t ctrl_d;

	always_comb
	begin
		ctrl_d = '0;
		case (pad_mode) // RL1
			`PAD_PUSH_PULL:
			begin
				ctrl_d.out = drv.level;
				ctrl_d.oe = drv.drive;
			end
			`PAD_OD_HIGH:
			begin
				ctrl_d.out = 1'b1;
				ctrl_d.oe = drv.drive & drv.level;
				ctrl_d.pull_up = 1'b1;
			end
			`PAD_HIGH_WEAK_DOWN:
			begin
				ctrl_d.out = 1'b1;
				ctrl_d.oe = drv.drive & drv.level;
				ctrl_d.pull_down = 1'b1;
			end
			`PAD_OD_LOW: // RL2
			begin
				ctrl_d.out = 1'b0;
				ctrl_d.oe = drv.drive & ~drv.level;
			end
			`PAD_LOW_WEAK_UP:
			begin
				ctrl_d.out = 1'b0;
				ctrl_d.oe = drv.drive & ~drv.level;
				ctrl_d.pull_up = 1'b1;
			end
			// Reserved codes release the pad rather than guess a driver
			default:
				ctrl_d = '0; // RL3
		endcase
	end

	// Open-drain low side is the startup mode, so the pad is released at reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ctrl_q <= '0;
		else
			ctrl_q <= ctrl_d;
	end

endmodule

// ### pkg/gpio_function_mux_pkg.sv
// Types shared by the pin function mux and its pad driver
package gpio_function_mux_pkg;

	typedef struct packed {
		logic [2:0] pad_mode;
		logic [4:0] func;
	} pin_cfg_t;

	typedef struct packed {
		logic drive;
		logic level;
	} pin_drive_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
	} pad_ctrl_t;

	typedef struct packed {
		logic undervoltage;
		logic tx_stuck;
		logic tx2_stuck;
		logic wake_pattern;
		logic wake_frame;
		logic bus_bias;
		logic wake_rise;
		logic wake_fall;
		logic tx_ready;
		logic listen_only;
		logic inhibit_two;
		logic irq_req;
	} core_status_t;

endpackage

// ### pkg/gpio_function_mux_regs.svh
// Register offsets, field positions, reset values and codes of the pin function mux
`ifndef GPIO_FUNCTION_MUX_REGS_SVH
`define GPIO_FUNCTION_MUX_REGS_SVH

`define ADDR_WIDTH 12
`define ADDR_WAKE_ENABLE 12'h012
`define ADDR_PIN_ONE_CONFIG 12'h042
`define ADDR_PIN_TWO_CONFIG 12'h043
`define ADDR_PIN_THREE_CONFIG 12'h044
`define ADDR_POLARITY 12'h045
`define ADDR_WAKE_STATUS 12'h063
`define ADDR_PIN_STATUS 12'h074

`define PAD_MODE_MSB 7
`define PAD_MODE_LSB 5
`define FUNC_MSB 4
`define FUNC_LSB 0
`define PIN_STATUS_TX_DISABLE_BIT 3

`define PAD_MODE_RESET 3'h3
`define FUNC_RESET 5'h00
`define POLARITY_RESET 3'h0
`define WAKE_ENABLE_RESET 3'h0

`define PAD_PUSH_PULL 3'h0
`define PAD_OD_HIGH 3'h1
`define PAD_HIGH_WEAK_DOWN 3'h2
`define PAD_OD_LOW 3'h3
`define PAD_LOW_WEAK_UP 3'h4

`define FN_REPEATER 5'h00
`define FN_DIG_IN 5'h01
`define FN_DIG_OUT 5'h02
`define FN_TX_DISABLE 5'h03
`define FN_IRQ 5'h04
`define FN_TX2_BOTH 5'h05
`define FN_RX2_BOTH 5'h06
`define FN_TX2_ONLY 5'h07
`define FN_RX2_ONLY 5'h08
`define FN_UNDERVOLT 5'h09
`define FN_TX_STUCK 5'h0A
`define FN_TX2_STUCK 5'h0B
`define FN_WAKE_PATTERN 5'h0C
`define FN_WAKE_FRAME 5'h0D
`define FN_BUS_BIAS 5'h0E
`define FN_WAKE_RISE 5'h0F
`define FN_WAKE_FALL 5'h10
`define FN_TX_READY 5'h11
`define FN_LISTEN_ONLY 5'h12
`define FN_EDGE_RISE 5'h13
`define FN_EDGE_FALL 5'h14
`define FN_EDGE_BOTH 5'h15
`define FN_INHIBIT 5'h16

`endif

// ### tb/gpio_function_mux_sva.sv
// Checker of the pin function mux, keeping its own copy of the registers it writes
`timescale 1ns/10ps
module gpio_function_mux_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr_en,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data_q,
	input wire logic general_pin_one_in,
	input wire logic general_pin_one_out,
	input wire logic general_pin_one_oe,
	input wire logic general_pin_two_in,
	input wire logic general_pin_three_in,
	input wire logic general_pin_three_out,
	input wire logic rxd_bus,
	input wire logic txd_primary,
	input wire logic transmit_disable_input,
	input wire gpio_function_mux_pkg::core_status_t core_status,
	input wire logic rxd_out_q,
	input wire logic can_tx_q,
	input wire logic tx_disable_q,
	input wire logic [2:0] wake_event_q
);
	logic [7:0] cfg_q [3];
	logic [2:0] pol_q, wen_q, prev_q;
	logic [1:0] up_q;
	wire [2:0] pin = {general_pin_three_in, general_pin_two_in, general_pin_one_in};
	wire [4:0] f1 = cfg_q[0][4:0];
	wire [4:0] f2 = cfg_q[1][4:0];
	wire tx_e = f2 == 5'h07 ? pin[1] : (f2 != 5'h05 | pin[1]) & txd_primary;
	wire dis_e = transmit_disable_input | (f1 == 5'h03 & pin[0]) | (f2 == 5'h03 & pin[1])
		| (cfg_q[2][4:0] == 5'h03 & pin[2]);
	wire wk_e = wen_q[0] & (f1 == 5'h15 | f1 == (pin[0] ? 5'h13 : 5'h14)) & (pin[0] ^ prev_q[0]);
	// Checks start three edges after reset, once the pins follow the configuration
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			cfg_q <= '{default: 8'h60};
			pol_q <= 3'h0;
			wen_q <= 3'h0;
			up_q <= 2'h0;
		end
		else
		begin
			up_q <= up_q + 2'(up_q != 2'h3);
			if (reg_wr_en && reg_addr inside {[12'h042:12'h044]})
				cfg_q[2'(reg_addr - 12'h042)] <= reg_wr_data;
			if (reg_wr_en && reg_addr == 12'h045)
				pol_q <= reg_wr_data[2:0];
			if (reg_wr_en && reg_addr == 12'h012)
				wen_q <= reg_wr_data[2:0];
		end
	always_ff @(posedge clk_sys)
		prev_q <= pin;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	chk_tx_select: assert property (up_q == 3 |-> can_tx_q == $past(tx_e)) else $error("bad can_tx_q");
	chk_tx_disable: assert property (up_q == 3 |-> tx_disable_q == $past(dis_e)) else $error("bad tx_disable_q");
	chk_rx_route: assert property (up_q == 3 |-> rxd_out_q == $past(f1 == 5'h08 | rxd_bus))
		else $error("bad rxd_out_q");
	chk_wake_edge: assert property (up_q == 3 |-> wake_event_q[0] == $past(wk_e)) else $error("bad wake");
	chk_cfg_read: assert property (up_q == 3 && reg_addr == 12'h043
		|=> reg_rd_data_q == $past(cfg_q[1])) else $error("bad read data");
	chk_dig_level: assert property (up_q == 3 && $past(cfg_q[0] == 8'h02)
		|-> general_pin_one_oe && general_pin_one_out == $past(pol_q[0])) else $error("bad digital out");
	chk_irq_level: assert property (up_q == 3 && $past(cfg_q[2] == 8'h04)
		|-> general_pin_three_out == $past(core_status.irq_req ~^ pol_q[2])) else $error("bad irq level");
	chk_status_pol: assert property (up_q == 3 && $past(cfg_q[2] == 8'h0E)
		|-> general_pin_three_out == $past(core_status.bus_bias ^ pol_q[2])) else $error("bad status");
	chk_low_only: assert property (up_q == 3 && $past(cfg_q[0][7:5] >= 3'h3)
		|-> !(general_pin_one_oe && general_pin_one_out)) else $error("low pad drove high");
endmodule
bind gpio_function_mux gpio_function_mux_chk chk (.*);

// ### tb/pin_far_side.sv
// Far side of the three pins: outside drivers, pull resistors and floating wires
`timescale 1ns/10ps
module pin_far_side (
	input wire logic clk_sys,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] pull_up,
	input wire logic [2:0] pull_down,
	input wire logic [2:0] ext_en,
	input wire logic [2:0] ext_val,
	output logic [2:0] level
);
	logic toggle_q = 1'b0;
	always @(posedge clk_sys)
		toggle_q <= ~toggle_q;
	// A floating pin changes every cycle, so no stale level can pass for a driven one
	always_comb
		for (int i = 0; i < 3; i++)
			level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pull_up[i] | (~pull_down[i] & toggle_q);
endmodule

// ### tb/testbench.sv
// Bench of the pin function mux: registers, pad modes and the pin functions
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr_en = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wr_data = 8'h00;
	logic repeat_src = 1'b0, rxd_bus = 1'b1, txd_primary = 1'b1, transmit_disable_input = 1'b0;
	gpio_function_mux_pkg::core_status_t core_status = '0;
	logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
	logic [7:0] reg_rd_data_q;
	logic [2:0] lvl, out, oe, pu, pd, wake_event_q;
	logic rxd_out_q, can_tx_q, tx_disable_q;
	int n_fail = 0, total_checks = 0, cyc = 0;
	always #4 clk_sys = ~clk_sys;
	gpio_function_mux dut (.*, .general_pin_one_in(lvl[0]), .general_pin_one_out(out[0]), .general_pin_one_oe(oe[0]),
		.general_pin_two_in(lvl[1]), .general_pin_two_out(out[1]), .general_pin_two_oe(oe[1]),
		.general_pin_three_in(lvl[2]), .general_pin_three_out(out[2]), .general_pin_three_oe(oe[2]),
		.pad_pull_up_q(pu), .pad_pull_down_q(pd));
	pin_far_side far (.clk_sys, .pin_out(out), .pin_oe(oe), .pull_up(pu), .pull_down(pd), .ext_en, .ext_val, .level(lvl));
	task automatic ck(string n, logic [7:0] s, logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk_sys);
		reg_wr_en = 1'b0;
	endtask
	// Pins follow a new config one edge after the write lands
	task automatic cfg(int i, logic [2:0] m, logic [4:0] f);
		wr(12'h042 + 12'(i), {m, f});
		@(negedge clk_sys);
	endtask
	task automatic rd(logic [11:0] a);
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
	endtask
	task automatic t_regs();
		rd(12'h043);
		ck("config", reg_rd_data_q, 8'h60);
		rd(12'h045);
		ck("polarity", reg_rd_data_q, 8'h00);
		wr(12'h045, 8'hFF);
		rd(12'h045);
		ck("polarity", reg_rd_data_q, 8'h07);
		wr(12'h100, 8'hFF);
		rd(12'h100);
		ck("unmapped", reg_rd_data_q, 8'h00);
	endtask
	task automatic t_repeat();
		for (int v = 0; v < 2; v++)
		begin
			repeat_src = v[0];
			@(negedge clk_sys);
			ck("repeater", 8'({oe[1], oe[1] & out[1]}), 8'({!v[0], 1'b0}));
		end
	endtask
	task automatic t_pad();
		logic hi;
		logic [7:0] e;
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 5; m++)
			begin
				wr(12'h045, 8'(p));
				cfg(0, 3'(m), 5'h02);
				hi = m == 0 || (p ? m inside {1, 2} : m inside {3, 4});
				e = 8'({hi, hi & p[0], m == 1 || m == 4, m == 2});
				ck("pad one", 8'({oe[0], oe[0] & out[0], pu[0], pd[0]}), e);
			end
	endtask
	task automatic t_tx();
		logic [4:0] f [3] = '{5'h05, 5'h07, 5'h01};
		ext_en = 3'h6;
		for (int i = 0; i < 3; i++)
		begin
			cfg(1, 3'h0, f[i]);
			for (int c = 0; c < 4; c++)
			begin
				{txd_primary, ext_val[1]} = 2'(c);
				@(negedge clk_sys);
				ck("can tx", 8'(can_tx_q), 8'(i == 0 ? c == 3 : i == 1 ? c[0] : c[1]));
			end
		end
		txd_primary = 1'b1;
		cfg(2, 3'h0, 5'h03);
		for (int c = 0; c < 4; c++)
		begin
			{transmit_disable_input, ext_val[2]} = 2'(c);
			@(negedge clk_sys);
			ck("tx disable", 8'(tx_disable_q), 8'(c != 0));
		end
		rd(12'h074);
		ck("pin status", reg_rd_data_q, 8'h0F);
		transmit_disable_input = 1'b0;
	endtask
	task automatic t_rx();
		for (int i = 0; i < 2; i++)
		begin
			cfg(0, 3'h0, i ? 5'h08 : 5'h06);
			for (int v = 0; v < 2; v++)
			begin
				rxd_bus = v[0];
				@(negedge clk_sys);
				ck("rx paths", 8'({rxd_out_q, out[0]}), 8'({v[0] | i[0], v[0]}));
			end
		end
	endtask
	task automatic t_status();
		cfg(1, 3'h0, 5'h05);
		for (int p = 0; p < 2; p++)
			for (int k = 0; k < 12; k++)
			begin
				wr(12'h045, 8'(p << 2));
				cfg(2, 3'h0, k == 10 ? 5'h16 : k == 11 ? 5'h04 : 5'(9 + k));
				for (int v = 0; v < 2; v++)
				begin
					core_status = 12'(v) << (11 - k);
					@(negedge clk_sys);
					ck("status", 8'(out[2]), 8'(v[0] ^ p[0] ^ (k == 11)));
				end
			end
		cfg(1, 3'h0, 5'h01);
		core_status = 12'h200;
		cfg(2, 3'h0, 5'h0B);
		ck("stuck gated", 8'(out[2]), 8'h01);
	endtask
	task automatic t_wake();
		ext_en = 3'h7;
		// Release pin one to a known low before any edge is qualified
		cfg(0, 3'h0, 5'h01);
		for (int c = 0; c < 4; c++)
		begin
			wr(12'h012, 8'(c != 3));
			cfg(0, 3'h0, c == 3 ? 5'h15 : 5'(19 + c));
			for (int v = 1; v >= 0; v--)
			begin
				ext_val[0] = v[0];
				@(negedge clk_sys);
				ck("wake", 8'(wake_event_q), 8'(c < 3 && (c == 2 || c[0] != v[0])));
			end
		end
		rd(12'h063);
		ck("wake status", reg_rd_data_q, 8'h01);
		wr(12'h063, 8'h01);
		rd(12'h063);
		ck("wake status", reg_rd_data_q, 8'h00);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		t_regs();
		t_repeat();
		t_pad();
		t_tx();
		t_rx();
		t_status();
		t_wake();
		print_verdict();
	end
endmodule
